// >>> hw/unused_placeholder_none.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> hw/wdrc_cfg.svh
// Purpose: constants of the watchdog and reset control block
// Assumes: 25 MHz system clock, registers reached over a plain port
// Notes:   every offset, field, reset value and count lives here
// What this block does
// - Option enabled forces the watchdog on; otherwise the key decides.
// - With option off, key 1010B stops the watchdog; other keys run it.
// - Power-up loads the key with 1010B, so watchdog off unless optioned.
// - Watchdog clear instructions do nothing while the watchdog is off.
// - Watchdog clock is crystal, system clock over four, or internal RC.
// - System clock over four source stops counting during sleep.
// - Period codes 000 to 111 select 2^8 to 2^15 watchdog clocks.
// - Upper five bits of the period register read as zero.
// - Overflow while running resets the device and sets the timeout flag.
// - Overflow in sleep wakes, sets timeout, clears only PC and stack.
// - Counter cleared by reset pin low, clear instructions and halt.
// - Option picks single or paired clear instruction scheme.
// - Single scheme: every single clear instruction clears the watchdog.
// - Paired scheme: both halves needed; repeating one half does nothing.
// - Power-on reset sets the program counter to zero.
// - Power-on sets all port data and port control registers high.
// - Reset pin held low inhibits normal operation.
// - After the pin rises, wait the reset delay, typically 100 ms.
// - Reset pin pulse while running clears the program counter.
// - Pin reset leaves the status flags unchanged.
// - Low supply detection applies the same full reset as the pin.
// - Power-on clears flags; pin keeps; run overflow sets TO; sleep both.
// - Sleep wake waits 1024 or 2 clocks for RC, 1024 for crystal.
`ifndef WDRC_CFG_SVH
`define WDRC_CFG_SVH
`define WDRC_CLK_HZ      25000000
`define WDRC_RSTD_MS     100
`define WDRC_RSTD_CYC    ((64'd`WDRC_RSTD_MS * 64'd`WDRC_CLK_HZ) / 64'd1000)
`define WDRC_SST_LONG    1024
`define WDRC_SST_SHORT   2
`define WDRC_DLY_W       24
`define WDRC_CNT_W       16
`define WDRC_MIN_EXP     8
`define WDRC_ADDR_PERIOD 3'h0
`define WDRC_ADDR_CONTROL_REGISTER_ONE  3'h1
`define WDRC_ADDR_STATUS 3'h2
`define WDRC_ADDR_PDATA  3'h3
`define WDRC_ADDR_PCTRL  3'h4
`define WDRC_PERIOD_RST  3'h7
`define WDRC_KEY_OFF     4'hA
`define WDRC_CTRLHI_RST  4'h8
`define WDRC_PORT_RST    8'hFF
`define WDRC_STAT_TO     0
`define WDRC_STAT_PD     1
`endif

// >>> hw/wdrc_pkg.sv
// Purpose: types of the watchdog and reset control block
// Assumes: widths taken from the constants header
// Notes:   state of each module is one packed struct
`include "wdrc_cfg.svh"
package wdrc_pkg;
  typedef enum logic [1:0] {
    CLK_LXT  = 2'h0,
    CLK_SYS4 = 2'h1,
    CLK_LOW_SPEED_INTERNAL_RC = 2'h3
  } wdrc_clksrc_e;

  typedef enum logic [1:0] {
    PH_HOLD  = 2'h0,
    PH_DELAY = 2'h1,
    PH_RUN   = 2'h3,
    PH_START = 2'h2
  } wdrc_phase_e;

  typedef struct packed {
    logic                   pin_s1;
    logic                   pin_s2;
    logic                   lvr_s1;
    logic                   lvr_s2;
    logic                   lxt_s1;
    logic                   lxt_s2;
    logic                   lxt_s3;
    logic                   low_speed_internal_rc_s1;
    logic                   low_speed_internal_rc_s2;
    logic                   low_speed_internal_rc_s3;
    logic [1:0]             div;
    wdrc_phase_e            phase;
    logic [`WDRC_DLY_W-1:0] dly;
    logic                   asleep;
    logic [1:0]             pend;
    logic                   to_flag;
    logic                   pd_flag;
    logic [2:0]             period;
    logic [3:0]             key;
    logic [3:0]             ctrl_hi;
    logic [7:0]             port_data;
    logic [7:0]             port_ctrl;
    logic [7:0]             rdata;
    logic                   pc_clear;
    logic                   wake;
    logic                   core_hold;
    logic                   wdt_clear;
    logic                   wdt_tick;
    logic                   wdt_run;
  } wdrc_state_s;

  typedef struct packed {
    logic [`WDRC_CNT_W-1:0] count;
    logic                   ovf;
  } wdrc_cnt_s;
endpackage : wdrc_pkg

// >>> hw/wdrc_top.sv
// Purpose: watchdog enable, clocking, clear schemes and reset sequencing
// Assumes: options and instruction strobes are on the system clock
// Notes:   pins and watchdog clock inputs pass two flip-flops first
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "wdrc_cfg.svh"
module wdrc_top #(
  parameter int unsigned RSTD_CYCLES = 32'(`WDRC_RSTD_CYC)
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  // Reset sources
  input  wire logic                  external_reset_pin,
  input  wire logic                  supply_low,
  // Watchdog clock pins
  input  wire logic                  low_freq_crystal,
  input  wire logic                  low_speed_internal_rc,
  // Configuration options
  input  wire logic                  opt_wdt_enable,
  input  wire wdrc_pkg::wdrc_clksrc_e opt_clk_src,
  input  wire logic                  opt_paired_clear,
  input  wire logic                  opt_short_startup,
  input  wire logic                  opt_crystal_osc,
  // Instruction strobes
  input  wire logic                  single_clear_instruction,
  input  wire logic                  first_half_clear_instruction,
  input  wire logic                  second_half_clear_instruction,
  input  wire logic                  halt_instruction,
  // Register port
  input  wire logic [2:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Core control
  output logic                       core_hold,
  output logic                       pc_stack_clear,
  output logic                       wake_pulse,
  output logic                       timeout_flag,
  output logic                       powerdown_flag,
  output logic                       wdt_running,
  // Port presets
  output logic      [7:0]            port_data,
  output logic      [7:0]            port_ctrl
);
  import wdrc_pkg::*;

  localparam logic [`WDRC_DLY_W-1:0] RSTD_LAST =
    `WDRC_DLY_W'(RSTD_CYCLES - 32'd1);
  localparam logic [`WDRC_DLY_W-1:0] SST_LONG_LAST =
    `WDRC_DLY_W'(`WDRC_SST_LONG - 1);
  localparam logic [`WDRC_DLY_W-1:0] SST_SHORT_LAST =
    `WDRC_DLY_W'(`WDRC_SST_SHORT - 1);

  // Power-on values; synchroniser flops start low so the pin counts as held
  localparam wdrc_state_s ST_RST = '{
    phase:     PH_HOLD,
    period:    `WDRC_PERIOD_RST,
    key:       `WDRC_KEY_OFF,
    ctrl_hi:   `WDRC_CTRLHI_RST,
    port_data: `WDRC_PORT_RST,
    port_ctrl: `WDRC_PORT_RST,
    pc_clear:  1'b1,
    core_hold: 1'b1,
    wdt_clear: 1'b1,
    default:   '0
  };

  wdrc_state_s st_q;
  wdrc_state_s st_d;
  wdrc_wdt_if  wdt_bus ();

  logic wdt_on;
  logic rst_evt;
  logic ovf;
  logic running;
  logic clr_single;
  logic clr_first;
  logic clr_second;

  assign wdt_on  = opt_wdt_enable || (st_q.key != `WDRC_KEY_OFF);
  assign rst_evt = !st_q.pin_s2 || st_q.lvr_s2;
  assign ovf     = wdt_bus.overflow;
  assign running = (st_q.phase == PH_RUN) && !st_q.asleep;
  // Clear instructions count only while running with the watchdog on
  assign clr_single = running && wdt_on && !opt_paired_clear &&
                      single_clear_instruction;
  assign clr_first  = running && wdt_on && opt_paired_clear &&
                      first_half_clear_instruction;
  assign clr_second = running && wdt_on && opt_paired_clear &&
                      second_half_clear_instruction;

  // Registers that the pin, low supply and running overflow put back
  function automatic wdrc_state_s reload(input wdrc_state_s s);
    wdrc_state_s r;
    r           = s;
    r.period    = `WDRC_PERIOD_RST;
    r.key       = `WDRC_KEY_OFF;
    r.ctrl_hi   = `WDRC_CTRLHI_RST;
    r.port_data = `WDRC_PORT_RST;
    r.port_ctrl = `WDRC_PORT_RST;
    r.pend      = 2'h0;
    r.wdt_clear = 1'b1;
    return r;
  endfunction : reload

  always_comb begin
    st_d         = st_q;
    st_d.pin_s1  = external_reset_pin;
    st_d.pin_s2  = st_q.pin_s1;
    st_d.lvr_s1  = supply_low;
    st_d.lvr_s2  = st_q.lvr_s1;
    st_d.lxt_s1  = low_freq_crystal;
    st_d.lxt_s2  = st_q.lxt_s1;
    st_d.lxt_s3  = st_q.lxt_s2;
    st_d.low_speed_internal_rc_s1 = low_speed_internal_rc;
    st_d.low_speed_internal_rc_s2 = st_q.low_speed_internal_rc_s1;
    st_d.low_speed_internal_rc_s3 = st_q.low_speed_internal_rc_s2;
    st_d.pc_clear  = 1'b0;
    st_d.wake      = 1'b0;
    st_d.wdt_clear = 1'b0;
    st_d.rdata     = 8'h00;

    // Instruction clock divider freezes with the core in sleep
    if (!st_q.asleep) begin
      st_d.div = st_q.div + 2'h1;
    end
    unique case (opt_clk_src)
      CLK_LXT:  st_d.wdt_tick = st_q.lxt_s2 && !st_q.lxt_s3;
      CLK_SYS4: st_d.wdt_tick = (st_q.div == 2'h3) && !st_q.asleep;
      CLK_LOW_SPEED_INTERNAL_RC: st_d.wdt_tick = st_q.low_speed_internal_rc_s2 && !st_q.low_speed_internal_rc_s3;
      default:  st_d.wdt_tick = 1'b0;
    endcase
    st_d.wdt_run = wdt_on && (st_q.phase == PH_RUN);

    if (reg_rd) begin
      unique case (reg_addr)
        `WDRC_ADDR_PERIOD: st_d.rdata = {5'h00, st_q.period};
        `WDRC_ADDR_CONTROL_REGISTER_ONE:  st_d.rdata = {st_q.ctrl_hi, st_q.key};
        `WDRC_ADDR_STATUS: st_d.rdata = {6'h00, st_q.pd_flag, st_q.to_flag};
        `WDRC_ADDR_PDATA:  st_d.rdata = st_q.port_data;
        `WDRC_ADDR_PCTRL:  st_d.rdata = st_q.port_ctrl;
        default:           st_d.rdata = 8'h00;
      endcase
    end

    if (rst_evt) begin
      // Pin low or low supply: hold the core, flags untouched
      st_d          = reload(st_d);
      st_d.phase    = PH_HOLD;
      st_d.asleep   = 1'b0;
      st_d.pc_clear = (st_q.phase != PH_HOLD);
    end else if (ovf && st_q.asleep) begin
      // Sleep overflow only restarts the core; registers survive
      st_d.wake     = 1'b1;
      st_d.pc_clear = 1'b1;
      st_d.to_flag  = 1'b1;
      st_d.pd_flag  = 1'b1;
      st_d.asleep   = 1'b0;
      st_d.pend     = 2'h0;
      st_d.phase    = PH_START;
      st_d.dly      = (opt_short_startup && !opt_crystal_osc) ?
                      SST_SHORT_LAST : SST_LONG_LAST;
    end else if (ovf) begin
      // Running overflow acts like a pin reset plus the timeout flag
      st_d          = reload(st_d);
      st_d.phase    = PH_DELAY;
      st_d.dly      = RSTD_LAST;
      st_d.pc_clear = 1'b1;
      st_d.to_flag  = 1'b1;
    end else begin
      unique case (st_q.phase)
        PH_HOLD: begin
          st_d.phase = PH_DELAY;
          st_d.dly   = RSTD_LAST;
        end
        PH_DELAY, PH_START: begin
          if (st_q.dly == '0) begin
            st_d.phase = PH_RUN;
          end else begin
            st_d.dly = st_q.dly - `WDRC_DLY_W'(1);
          end
        end
        PH_RUN: begin
          if (reg_wr && !st_q.asleep) begin
            unique case (reg_addr)
              `WDRC_ADDR_PERIOD: st_d.period = reg_wdata[2:0];
              `WDRC_ADDR_CONTROL_REGISTER_ONE: begin
                st_d.key     = reg_wdata[3:0];
                st_d.ctrl_hi = reg_wdata[7:4];
              end
              `WDRC_ADDR_PDATA:  st_d.port_data = reg_wdata;
              `WDRC_ADDR_PCTRL:  st_d.port_ctrl = reg_wdata;
              default: ;
            endcase
          end
          if (clr_single) begin
            st_d.wdt_clear = 1'b1;
          end
          if (clr_first || clr_second) begin
            // A repeated half is ignored until its partner arrives
            if ((clr_first && clr_second) ||
                (clr_first && st_q.pend[1]) ||
                (clr_second && st_q.pend[0])) begin
              st_d.wdt_clear = 1'b1;
              st_d.pend      = 2'h0;
            end else begin
              st_d.pend = st_q.pend | {clr_second, clr_first};
            end
          end
          if (st_d.wdt_clear) begin
            st_d.to_flag = 1'b0;
            st_d.pd_flag = 1'b0;
          end
          if (running && halt_instruction) begin
            st_d.wdt_clear = 1'b1;
            st_d.asleep    = 1'b1;
            st_d.pend      = 2'h0;
            st_d.pd_flag   = 1'b1;
            st_d.to_flag   = 1'b0;
          end
        end
        default: st_d.phase = PH_HOLD;
      endcase
    end
    st_d.core_hold = (st_d.phase != PH_RUN) || st_d.asleep;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign wdt_bus.tick   = st_q.wdt_tick;
  assign wdt_bus.clear  = st_q.wdt_clear;
  assign wdt_bus.run    = st_q.wdt_run;
  assign wdt_bus.period = st_q.period;

  wdrc_wdt_counter u_counter (
    .clock   (clock),
    .reset_n (reset_n),
    .bus     (wdt_bus)
  );

  assign reg_rdata      = st_q.rdata;
  assign core_hold      = st_q.core_hold;
  assign pc_stack_clear = st_q.pc_clear;
  assign wake_pulse     = st_q.wake;
  assign timeout_flag   = st_q.to_flag;
  assign powerdown_flag = st_q.pd_flag;
  assign wdt_running    = st_q.wdt_run;
  assign port_data      = st_q.port_data;
  assign port_ctrl      = st_q.port_ctrl;

  a_key_disables: assert property (@(posedge clock) disable iff (!reset_n)
    (!opt_wdt_enable && st_q.key == `WDRC_KEY_OFF) |=> !st_q.wdt_run)
    else $error("watchdog ran with disabling key");

  a_option_forces: assert property (@(posedge clock) disable iff (!reset_n)
    (opt_wdt_enable && st_q.phase == PH_RUN) |=> st_q.wdt_run)
    else $error("watchdog off although option enables it");

  a_sleep_no_tick: assert property (@(posedge clock) disable iff (!reset_n)
    (st_q.asleep && opt_clk_src == CLK_SYS4) |=> !st_q.wdt_tick)
    else $error("divided system clock ticked in sleep");

  a_run_ovf_reset: assert property (@(posedge clock) disable iff (!reset_n)
    (ovf && !st_q.asleep && !rst_evt)
    |=> (st_q.phase == PH_DELAY && st_q.to_flag && st_q.pc_clear &&
         st_q.key == `WDRC_KEY_OFF))
    else $error("running overflow did not reset");

  a_sleep_ovf_wake: assert property (@(posedge clock) disable iff (!reset_n)
    (ovf && st_q.asleep && !rst_evt)
    |=> (st_q.wake && st_q.to_flag && st_q.pd_flag &&
         st_q.phase == PH_START && st_q.period == $past(st_q.period)))
    else $error("sleep overflow did not wake cleanly");

  a_pin_holds: assert property (@(posedge clock) disable iff (!reset_n)
    rst_evt |=> (st_q.core_hold && st_q.phase == PH_HOLD &&
                 st_q.to_flag == $past(st_q.to_flag)))
    else $error("core not held during pin reset");

  a_delay_end: assert property (@(posedge clock) disable iff (!reset_n)
    (st_q.phase == PH_DELAY && st_q.dly == '0 && !rst_evt && !ovf)
    |=> (st_q.phase == PH_RUN) ##1 !st_q.core_hold || st_q.asleep ||
        st_q.phase != PH_RUN)
    else $error("reset delay did not end in run");

  a_halt_clears: assert property (@(posedge clock) disable iff (!reset_n)
    (running && halt_instruction && !rst_evt && !ovf)
    |=> (st_q.wdt_clear && st_q.asleep && st_q.pd_flag && !st_q.to_flag)
    ##1 !wdt_bus.tick || st_q.asleep)
    else $error("halt did not clear and sleep");

  a_half_repeat: assert property (@(posedge clock) disable iff (!reset_n)
    (clr_first && !clr_second && !st_q.pend[1] && !rst_evt && !ovf &&
     !halt_instruction) |=> !st_q.wdt_clear)
    else $error("lone first half cleared the watchdog");

  a_off_no_clear: assert property (@(posedge clock) disable iff (!reset_n)
    (!wdt_on && !halt_instruction && !rst_evt && !ovf &&
     st_q.phase == PH_RUN) |=> !st_q.wdt_clear)
    else $error("clear acted with watchdog off");

  a_period_upper: assert property (@(posedge clock) disable iff (!reset_n)
    (reg_rd && reg_addr == `WDRC_ADDR_PERIOD)
    |=> (reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] == $past(st_q.period)))
    else $error("period register read wrong");
endmodule : wdrc_top
`default_nettype wire

// >>> hw/wdrc_wdt_counter.sv
// Purpose: watchdog count with selectable power-of-two length
// Assumes: tick is a one-cycle pulse per watchdog clock period
// Notes:   overflow is a registered one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
`include "wdrc_cfg.svh"
module wdrc_wdt_counter (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   reset_n,
  // Control link
  wdrc_wdt_if.cnt     bus
);
  import wdrc_pkg::*;

  wdrc_cnt_s st_q;
  wdrc_cnt_s st_d;

  // Last count value before the wrap for a period code
  function automatic logic [`WDRC_CNT_W-1:0] last_count(
    input logic [2:0] code
  );
    logic [`WDRC_CNT_W-1:0] len;
    len = `WDRC_CNT_W'(1) << (`WDRC_MIN_EXP + 32'(code));
    return len - `WDRC_CNT_W'(1);
  endfunction : last_count

  always_comb begin
    st_d     = st_q;
    st_d.ovf = 1'b0;
    if (bus.clear || !bus.run) begin
      st_d.count = '0;
    end else if (bus.tick) begin
      if (st_q.count == last_count(bus.period)) begin
        st_d.count = '0;
        st_d.ovf   = 1'b1;
      end else begin
        st_d.count = st_q.count + `WDRC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.overflow = st_q.ovf;

  a_wrap_exact: assert property (@(posedge clock) disable iff (!reset_n)
    (bus.tick && bus.run && !bus.clear &&
     st_q.count == last_count(bus.period))
    |=> (st_q.ovf && st_q.count == '0))
    else $error("watchdog did not wrap at selected length");

  a_no_early_ovf: assert property (@(posedge clock) disable iff (!reset_n)
    (bus.tick && bus.run && !bus.clear &&
     st_q.count != last_count(bus.period))
    |=> (!st_q.ovf && st_q.count == $past(st_q.count) + `WDRC_CNT_W'(1)))
    else $error("watchdog overflowed before its length");
endmodule : wdrc_wdt_counter
`default_nettype wire

// >>> hw/wdrc_wdt_if.sv
// Purpose: link between reset control and the watchdog counter
// Assumes: both ends on the system clock
// Notes:   tick, clear and run are registered by the control end
`timescale 1ns/100ps
`default_nettype none
interface wdrc_wdt_if;
  logic       tick;
  logic       clear;
  logic       run;
  logic [2:0] period;
  logic       overflow;
  modport ctrl (output tick, clear, run, period, input overflow);
  modport cnt  (input tick, clear, run, period, output overflow);
endinterface : wdrc_wdt_if
`default_nettype wire

// >>> test/tb.sv
// Purpose: self-checking bench of the watchdog and reset control block
// Assumes: short reset delay parameter so overflow resets stay quick
// Notes:   watchdog clock pins get slow waves of unrelated phase
`timescale 1ns/100ps
`default_nettype none
module tb;
  import wdrc_pkg::*;
  localparam int RSTD = 20;
  logic         clock, reset_n, supply_low, xtal_clk, rc_clk, pin, pin_go;
  logic         opt_en, opt_pair, opt_short, opt_xtal, reg_wr, reg_rd;
  logic [3:0]   op;
  wdrc_clksrc_e src;
  logic [2:0]   reg_addr;
  logic [7:0]   reg_wdata, reg_rdata, port_data, port_ctrl;
  logic         core_hold, pcs_clr, wake, tmo_flag, pd_flag, running;
  int           err_total = 0;
  int           cmp_count = 0;
  int           n;

  wdrc_reset_net i_net (.clock(clock), .go(pin_go), .pin(pin));
  wdrc_top #(.RSTD_CYCLES(RSTD)) i_dut (
    .clock(clock), .reset_n(reset_n), .external_reset_pin(pin),
    .supply_low(supply_low), .low_freq_crystal(xtal_clk),
    .low_speed_internal_rc(rc_clk), .opt_wdt_enable(opt_en),
    .opt_clk_src(src), .opt_paired_clear(opt_pair),
    .opt_short_startup(opt_short), .opt_crystal_osc(opt_xtal),
    .single_clear_instruction(op[0]), .first_half_clear_instruction(op[1]),
    .second_half_clear_instruction(op[2]), .halt_instruction(op[3]),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_hold(core_hold),
    .pc_stack_clear(pcs_clr), .wake_pulse(wake), .timeout_flag(tmo_flag),
    .powerdown_flag(pd_flag), .wdt_running(running),
    .port_data(port_data), .port_ctrl(port_ctrl));

  task automatic chk8(logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(logic got, logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask : chk1
  task automatic step(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : step
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [2:0] a, logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk8(reg_rdata, e);
  endtask : rd
  task automatic pulse(logic [3:0] v);
    @(posedge clock);
    op <= v;
    @(posedge clock);
    op <= 4'h0;
    #1;
  endtask : pulse
  function automatic logic sig(int k);
    case (k)
      0: return core_hold;
      1: return tmo_flag;
      2: return wake;
      default: return pcs_clr;
    endcase
  endfunction : sig
  // Bounded wait; n holds the cycles it took
  task automatic wt(int k, logic v, int lim);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      step(1);
      n++;
    end
    chk1(sig(k), v);
  endtask : wt

  task automatic t_boot;
    wt(0, 1'b0, 100);
    chk8({6'h0, tmo_flag, pd_flag}, 8'h00);
    chk1(running, 1'b0);
    rd(0, 8'h07);
    rd(1, 8'h8A);
    rd(3, 8'hFF);
    rd(4, 8'hFF);
    chk8(port_data, 8'hFF);
    chk8(port_ctrl, 8'hFF);
    rd(6, 8'h00);
    wr(0, 8'hF8);
    rd(0, 8'h00);
    wr(1, 8'h85);
    step(2);
    chk1(running, 1'b1);
    wr(1, 8'h8A);
    step(2);
    chk1(running, 1'b0);
    opt_en <= 1'b1;
    step(2);
    chk1(running, 1'b1);
    opt_en <= 1'b0;
    step(2);
    $display("test boot done");
  endtask : t_boot

  task automatic t_ovf;
    wdrc_clksrc_e s [3] = '{CLK_SYS4, CLK_LXT, CLK_LOW_SPEED_INTERNAL_RC};
    int           e [3] = '{1024, 1536, 2048};
    for (int i = 0; i < 3; i++) begin
      src <= s[i];
      pulse(4'h1);
      if (i > 0) chk1(tmo_flag, 1'b1);
      wr(1, 8'h85);
      wr(0, 8'h00);
      if (i == 0) wr(3, 8'h5A);
      pulse(4'h1);
      wt(1, 1'b1, 2200);
      chk1(n >= e[i] - 16 && n <= e[i] + 16, 1'b1);
      chk1(pcs_clr && core_hold && !pd_flag, 1'b1);
      chk8(port_data, 8'hFF);
      wt(0, 1'b0, 60);
      chk1(n >= RSTD, 1'b1);
      rd(1, 8'h8A);
      rd(0, 8'h07);
    end
    $display("test overflow done");
  endtask : t_ovf

  task automatic t_clear;
    src <= CLK_SYS4;
    opt_pair <= 1'b0;
    wr(0, 8'h00);
    wr(1, 8'h85);
    pulse(4'h1);
    repeat (3) begin
      step(600);
      pulse(4'h1);
    end
    chk1(tmo_flag, 1'b0);
    opt_pair <= 1'b1;
    repeat (4) begin
      step(300);
      pulse(4'h2);
      step(300);
      pulse(4'h4);
    end
    chk1(tmo_flag, 1'b0);
    // Both lone halves land before the time-out, so a repeat must not clear
    repeat (2) begin
      step(400);
      pulse(4'h2);
    end
    chk1(tmo_flag, 1'b0);
    wt(1, 1'b1, 400);
    wt(0, 1'b0, 1000);
    opt_pair <= 1'b0;
    $display("test clear done");
  endtask : t_clear

  task automatic t_sleep;
    src <= CLK_SYS4;
    wr(0, 8'h00);
    wr(1, 8'h85);
    pulse(4'h8);
    chk8({5'h0, core_hold, tmo_flag, pd_flag}, 8'h05);
    step(1500);
    chk1(tmo_flag, 1'b0);
    @(posedge clock);
    pin_go <= 1'b1;
    @(posedge clock);
    pin_go <= 1'b0;
    wt(3, 1'b1, 10);
    chk8({5'h0, core_hold, tmo_flag, pd_flag}, 8'h05);
    wt(0, 1'b0, 80);
    chk1(n > RSTD, 1'b1);
    @(posedge clock);
    supply_low <= 1'b1;
    wt(3, 1'b1, 10);
    @(posedge clock);
    supply_low <= 1'b0;
    wt(0, 1'b0, 80);
    rd(1, 8'h8A);
    src <= CLK_LOW_SPEED_INTERNAL_RC;
    wr(0, 8'h00);
    wr(1, 8'h85);
    pulse(4'h8);
    wt(2, 1'b1, 2200);
    chk1(n >= 2030 && n <= 2070, 1'b1);
    chk8({5'h0, pcs_clr, tmo_flag, pd_flag}, 8'h07);
    wt(0, 1'b0, 1100);
    chk1(n >= 1020 && n <= 1030, 1'b1);
    rd(1, 8'h85);
    opt_short <= 1'b1;
    pulse(4'h8);
    wt(2, 1'b1, 2200);
    wt(0, 1'b0, 10);
    chk1(n <= 4, 1'b1);
    // A crystal system clock ignores the short start-up option
    opt_xtal <= 1'b1;
    pulse(4'h8);
    wt(2, 1'b1, 2200);
    wt(0, 1'b0, 1100);
    chk1(n >= 1020 && n <= 1030, 1'b1);
    $display("test sleep done");
  endtask : t_sleep

  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    xtal_clk = 1'b0;
    #3;
    forever #120 xtal_clk = ~xtal_clk;
  end
  initial begin
    rc_clk = 1'b0;
    #7;
    forever #160 rc_clk = ~rc_clk;
  end
  // About two and a half times the expected run length
  initial begin
    #2000000;
    err_total++;
    final_report();
  end
  initial begin
    {reset_n, supply_low, pin_go, opt_en, opt_pair, opt_short, opt_xtal} = '0;
    {reg_wr, reg_rd, op, reg_addr, reg_wdata} = '0;
    src = CLK_SYS4;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    t_boot();
    t_ovf();
    t_clear();
    t_sleep();
    final_report();
  end
endmodule : tb
`default_nettype wire

// >>> test/wdrc_reset_net.sv
// Purpose: reset pin network, RC hold at power-up plus a push switch
// Assumes: the pin is pulled up once the hold has run out
// Notes:   go restarts the low hold, as pressing the switch would
`timescale 1ns/100ps
`default_nettype none
module wdrc_reset_net #(
  parameter int LOW_CYC = 10
) (
  // Clock and switch
  input  wire logic clock,
  input  wire logic go,
  // Reset pin
  output var  logic pin
);
  int cnt = LOW_CYC;
  // Capacitor keeps the pin low for a while after each press
  always @(posedge clock) begin
    if (go) begin
      cnt <= LOW_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    pin <= (cnt == 0) && !go;
  end
endmodule : wdrc_reset_net
`default_nettype wire
